/* File: rtl/rgpc_consts.svh */
// Offsets, field positions, reset values and sizes for the pin configuration block
`ifndef RGPC_CONSTS_SVH
`define RGPC_CONSTS_SVH

`define RGPC_NPINS        14
`define RGPC_OFS_STS      8'h1C
`define RGPC_OFS_B1P0     8'h23
`define RGPC_OFS_B1P1     8'h24
`define RGPC_OFS_B1P2     8'h25
`define RGPC_OFS_B1P3     8'h26
`define RGPC_OFS_B1P4     8'h27
`define RGPC_OFS_B1P5     8'h29
`define RGPC_OFS_B1P6     8'h2A
`define RGPC_OFS_B1P7     8'h2B
`define RGPC_OFS_KBD_DATA 8'h2C
`define RGPC_OFS_KBD_CLK  8'h2D
`define RGPC_OFS_P27      8'h32
`define RGPC_OFS_P30      8'h33
`define RGPC_OFS_P60      8'h47
`define RGPC_OFS_P61      8'h48
`define RGPC_OFS_DATA1    8'h4B
`define RGPC_OFS_DATA2    8'h4C
`define RGPC_OFS_DATA3    8'h4D
`define RGPC_OFS_DATA6    8'h50

`define RGPC_BIT_DIR      0
`define RGPC_BIT_POL      1
`define RGPC_BIT_ALT      2
`define RGPC_BIT_OD       7
`define RGPC_STS_MASK     6'h33
`define RGPC_STS_W1C      8'h3F

`define RGPC_RST_STS      6'h00
`define RGPC_RST_GPIO     8'h01
`define RGPC_RST_KBD      8'h8C
`define RGPC_RST_P30      8'h05
`define RGPC_MASK_1BIT    8'h87
`define RGPC_MASK_2BIT    8'h8F

`define RGPC_IDX_KBD_DATA 4
`define RGPC_IDX_NONE     4'hF

`endif

/* File: rtl/rgpc_pkg.sv */
// Types shared by the pin configuration block
package rgpc_pkg;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rgpc_bus_t;

    // Pin function selected by a configuration byte
    typedef enum logic [1:0] {
        RGPC_FN_GPIO   = 2'b00,
        RGPC_FN_ALT    = 2'b01,
        RGPC_FN_PORT17 = 2'b10,
        RGPC_FN_EDGE   = 2'b11
    } rgpc_fn_t;

    // All state of the block
    typedef struct packed {
        logic [13:0][7:0] cfg;
        logic [13:0]      dout;
        logic [5:0]       sts;
        logic [13:0]      s1;
        logic [13:0]      s2;
        logic [13:0]      s3;
        logic [7:0]       rdata;
    } rgpc_state_t;

endpackage

/* File: rtl/rgpc_top.sv */
// Runtime pin configuration, pin data and either-edge event status
//
// Behaviour
// - Writing one clears status bits 5:0; writing zero leaves them.
// - Edge on keyboard data pin in edge mode sets status bit 0.
// - Edge on keyboard clock pin in edge mode sets status bit 1.
// - Edges on pins six-zero and six-one in edge mode set bits 4, 5.
// - Status bits 2, 3, 7, 6 read as zero.
// - Status register resets to zero.
// - Config bit 0 one makes pin input, zero makes it output.
// - Config bit 1 one inverts the pin sense.
// - Config bit 7 one gives open drain, zero push-pull.
// - Bank-one bit 2 routes the serial-port-3 signal to the pin.
// - Bank-one configuration registers reset to 0x01.
// - Keyboard data pin: bits 3:2 select data, edge input 0, GPIO.
// - Keyboard clock pin: bits 3:2 select clock, edge input 1, GPIO.
// - Pin two-seven: bits 3:2 select port-17, management irq, or GPIO.
// - Pin three-zero: bit 2 selects front-panel reset, reset value 0x05.
// - Data registers show pin values, bank one at 0x4B, bit n pin n.
`timescale 1ns/1ns
`include "rgpc_consts.svh"

module rgpc_top (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Pins: 0-7 bank one, 8 kbd data, 9 kbd clock, 10 two-seven,
    // 11 three-zero, 12 six-zero, 13 six-one
    input  wire logic [13:0] pin_in,
    output logic      [13:0] pin_out,
    output logic      [13:0] pin_oe,
    // Function side: serial 3, keyboard, management irq, front-panel reset
    input  wire logic [13:0] func_out,
    input  wire logic        kbc_port_17_output,
    output logic      [13:0] func_in,
    output logic      [13:0] func_sel
);

    rgpc_pkg::rgpc_state_t st_reg;
    rgpc_pkg::rgpc_state_t st_next;
    rgpc_pkg::rgpc_bus_t   bus;
    logic [13:0]           lvl;
    logic [13:0]           chg;
    logic [5:0]            sts_set;
    logic [5:0]            sts_clr;
    logic [3:0]            wr_idx;
    logic [3:0]            rd_idx;

    // Map an address to a configuration slot
    function automatic logic [3:0] cfg_index(input logic [7:0] a);
        case (a)
            `RGPC_OFS_B1P0: cfg_index = 4'h0;
            `RGPC_OFS_B1P1: cfg_index = 4'h1;
            `RGPC_OFS_B1P2: cfg_index = 4'h2;
            `RGPC_OFS_B1P3: cfg_index = 4'h3;
            `RGPC_OFS_B1P4: cfg_index = 4'h4;
            `RGPC_OFS_B1P5: cfg_index = 4'h5;
            `RGPC_OFS_B1P6: cfg_index = 4'h6;
            `RGPC_OFS_B1P7: cfg_index = 4'h7;
            `RGPC_OFS_KBD_DATA: cfg_index = 4'h8;
            `RGPC_OFS_KBD_CLK:  cfg_index = 4'h9;
            `RGPC_OFS_P27:  cfg_index = 4'hA;
            `RGPC_OFS_P30:  cfg_index = 4'hB;
            `RGPC_OFS_P60:  cfg_index = 4'hC;
            `RGPC_OFS_P61:  cfg_index = 4'hD;
            default:        cfg_index = `RGPC_IDX_NONE;
        endcase
    endfunction

    // Writable bits per slot; reserved bits read back as zero
    function automatic logic [7:0] cfg_mask(input int i);
        if (i == 8 || i == 9 || i >= 10 && i != 11) begin
            cfg_mask = `RGPC_MASK_2BIT;
        end else begin
            cfg_mask = `RGPC_MASK_1BIT;
        end
    endfunction

    // Reset value per slot
    function automatic logic [7:0] cfg_reset(input int i);
        if (i == 8 || i == 9) begin
            cfg_reset = `RGPC_RST_KBD;
        end else if (i == 11) begin
            cfg_reset = `RGPC_RST_P30;
        end else begin
            cfg_reset = `RGPC_RST_GPIO;
        end
    endfunction

    // Function a configuration byte selects for a pin
    function automatic rgpc_pkg::rgpc_fn_t pin_fn(input int i, input logic [7:0] c);
        pin_fn = rgpc_pkg::RGPC_FN_GPIO;
        if (i <= 7 || i == 11) begin
            if (c[`RGPC_BIT_ALT]) begin
                pin_fn = rgpc_pkg::RGPC_FN_ALT;
            end
        end else if (i == 10) begin
            case (c[3:2])
                2'b10:   pin_fn = rgpc_pkg::RGPC_FN_PORT17;
                2'b01:   pin_fn = rgpc_pkg::RGPC_FN_ALT;
                default: pin_fn = rgpc_pkg::RGPC_FN_GPIO;
            endcase
        end else begin
            case (c[3:2])
                2'b11:   pin_fn = (i <= 9) ? rgpc_pkg::RGPC_FN_ALT : rgpc_pkg::RGPC_FN_GPIO;
                2'b10:   pin_fn = rgpc_pkg::RGPC_FN_EDGE;
                default: pin_fn = rgpc_pkg::RGPC_FN_GPIO;
            endcase
        end
    endfunction

    assign bus.addr  = addr;
    assign bus.wdata = wdata;
    assign bus.wr    = wr;
    assign bus.rd    = rd;
    assign wr_idx    = cfg_index(bus.addr);
    assign rd_idx    = wr_idx;
    assign rdata     = st_reg.rdata;

    // Pin level after polarity and the per-pin output drive
    genvar g;
    generate
        for (g = 0; g < `RGPC_NPINS; g++) begin : g_pin
            rgpc_pkg::rgpc_fn_t fn;
            logic               val;
            assign fn  = pin_fn(g, st_reg.cfg[g]);
            assign lvl[g] = st_reg.s2[g] ^ st_reg.cfg[g][`RGPC_BIT_POL];
            // Compare settled samples; the first sync stage is never looked at
            assign chg[g] = st_reg.s2[g] ^ st_reg.s3[g];
            assign func_in[g]  = lvl[g];
            assign func_sel[g] = (fn == rgpc_pkg::RGPC_FN_ALT);
            always_comb begin
                case (fn)
                    rgpc_pkg::RGPC_FN_ALT:    val = func_out[g];
                    rgpc_pkg::RGPC_FN_PORT17: val = kbc_port_17_output;
                    default:                  val = st_reg.dout[g];
                endcase
            end
            // Open drain only ever pulls low; it never drives a one
            always_comb begin
                if (st_reg.cfg[g][`RGPC_BIT_DIR]) begin
                    pin_out[g] = 1'b0;
                    pin_oe[g]  = 1'b0;
                end else if (st_reg.cfg[g][`RGPC_BIT_OD]) begin
                    pin_out[g] = 1'b0;
                    pin_oe[g]  = ~(val ^ st_reg.cfg[g][`RGPC_BIT_POL]);
                end else begin
                    pin_out[g] = val ^ st_reg.cfg[g][`RGPC_BIT_POL];
                    pin_oe[g]  = 1'b1;
                end
            end
        end
    endgenerate

    // Status events; a set in the same cycle as a clear wins
    always_comb begin
        sts_set    = 6'h00;
        sts_set[0] = chg[8] && pin_fn(8, st_reg.cfg[8]) == rgpc_pkg::RGPC_FN_EDGE;
        sts_set[1] = chg[9] && pin_fn(9, st_reg.cfg[9]) == rgpc_pkg::RGPC_FN_EDGE;
        sts_set[4] = chg[12] && pin_fn(12, st_reg.cfg[12]) == rgpc_pkg::RGPC_FN_EDGE;
        sts_set[5] = chg[13] && pin_fn(13, st_reg.cfg[13]) == rgpc_pkg::RGPC_FN_EDGE;
        sts_clr    = 6'h00;
        if (bus.wr && bus.addr == `RGPC_OFS_STS) begin
            sts_clr = bus.wdata[5:0];
        end
    end

    // Next state: registers, data latches, samplers and read data
    always_comb begin
        st_next      = st_reg;
        st_next.s1   = pin_in;
        st_next.s2   = st_reg.s1;
        st_next.s3   = st_reg.s2;
        st_next.sts  = ((st_reg.sts & ~sts_clr) | sts_set) & `RGPC_STS_MASK;
        if (bus.wr) begin
            if (wr_idx != `RGPC_IDX_NONE) begin
                st_next.cfg[wr_idx] = bus.wdata & cfg_mask(int'(wr_idx));
            end
            case (bus.addr)
                `RGPC_OFS_DATA1: st_next.dout[7:0] = bus.wdata;
                `RGPC_OFS_DATA2: begin
                    st_next.dout[8]  = bus.wdata[1];
                    st_next.dout[9]  = bus.wdata[2];
                    st_next.dout[10] = bus.wdata[7];
                end
                `RGPC_OFS_DATA3: st_next.dout[11] = bus.wdata[0];
                `RGPC_OFS_DATA6: st_next.dout[13:12] = bus.wdata[1:0];
                default: ;
            endcase
        end
        // Read data stand one cycle after the strobe and only then
        st_next.rdata = 8'h00;
        if (bus.rd) begin
            if (rd_idx != `RGPC_IDX_NONE) begin
                st_next.rdata = st_reg.cfg[rd_idx];
            end else begin
                case (bus.addr)
                    `RGPC_OFS_STS:   st_next.rdata = {2'b00, st_reg.sts};
                    `RGPC_OFS_DATA1: st_next.rdata = lvl[7:0];
                    `RGPC_OFS_DATA2: st_next.rdata = {lvl[10], 4'h0, lvl[9:8], 1'b0};
                    `RGPC_OFS_DATA3: st_next.rdata = {7'h00, lvl[11]};
                    `RGPC_OFS_DATA6: st_next.rdata = {6'h00, lvl[13:12]};
                    default:         st_next.rdata = 8'h00;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `RGPC_NPINS; i++) begin
                st_reg.cfg[i] <= cfg_reset(i);
            end
            st_reg.dout  <= 14'h0000;
            st_reg.sts   <= `RGPC_RST_STS;
            st_reg.s1    <= 14'h0000;
            st_reg.s2    <= 14'h0000;
            st_reg.s3    <= 14'h0000;
            st_reg.rdata <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // Checks
    sequence s_kbd_data_edge;
        st_reg.cfg[8][3:2] == 2'b10 && chg[8];
    endsequence

    sequence s_clear0;
        wr && addr == `RGPC_OFS_STS && wdata[0] && !sts_set[0];
    endsequence

    property p_clear;
        @(posedge clock) disable iff (rst) s_clear0 |=> !st_reg.sts[0];
    endproperty
    a_clear: assert property (p_clear) else $error("status bit 0 not cleared");

    property p_kbd_data;
        @(posedge clock) disable iff (rst) s_kbd_data_edge |=> st_reg.sts[0];
    endproperty
    a_kbd_data: assert property (p_kbd_data) else $error("kbd data edge lost");

    // The status flop takes the event one edge after the change is seen
    property p_kbd_clock;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[9][3:2] == 2'b10 && $changed(st_reg.s2[9])) |=> st_reg.sts[1];
    endproperty
    a_kbd_clock: assert property (p_kbd_clock) else $error("kbd clock edge lost");

    property p_p60;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[12][3:2] == 2'b10 && st_reg.s2[12] != st_reg.s3[12])
            |=> st_reg.sts[4];
    endproperty
    a_p60: assert property (p_p60) else $error("pin six-zero edge lost");

    property p_rsvd;
        @(posedge clock) disable iff (rst)
            (rd && addr == `RGPC_OFS_STS) |=> rdata[7:6] == 2'b00 && rdata[3:2] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");

    property p_dir;
        @(posedge clock) disable iff (rst) st_reg.cfg[0][0] |-> !pin_oe[0];
    endproperty
    a_dir: assert property (p_dir) else $error("input pin driven");

    property p_od;
        @(posedge clock) disable iff (rst)
            st_reg.cfg[3][`RGPC_BIT_OD] |-> !(pin_oe[3] && pin_out[3]);
    endproperty
    a_od: assert property (p_od) else $error("open drain drove high");

    property p_alt;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[1][2:0] == 3'b100 && !st_reg.cfg[1][7]) |-> pin_out[1] == func_out[1];
    endproperty
    a_alt: assert property (p_alt) else $error("serial signal not routed");

    property p_data;
        @(posedge clock) disable iff (rst)
            (rd && addr == `RGPC_OFS_DATA1) |=> rdata == $past(lvl[7:0]);
    endproperty
    a_data: assert property (p_data) else $error("data register mismatch");

    // Only the second sync stage is watched; the first may be metastable
    property p_sync;
        @(posedge clock) disable iff (rst)
            $rose(st_reg.s2[13]) && st_reg.cfg[13][3:2] == 2'b10 |=> st_reg.sts[5];
    endproperty
    a_sync: assert property (p_sync) else $error("synchronised edge lost");

    property p_p61;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[13][3:2] == 2'b10 && chg[13]) |=> st_reg.sts[5];
    endproperty
    a_p61: assert property (p_p61) else $error("pin six-one edge lost");

    // Zero positions of a status write keep a pending event
    property p_keep;
        @(posedge clock) disable iff (rst)
            (wr && addr == `RGPC_OFS_STS && !wdata[4] && st_reg.sts[4]) |=> st_reg.sts[4];
    endproperty
    a_keep: assert property (p_keep) else $error("status bit 4 lost on zero write");

    property p_clear4;
        @(posedge clock) disable iff (rst)
            (wr && addr == `RGPC_OFS_STS && wdata[4] && !sts_set[4]) |=> !st_reg.sts[4];
    endproperty
    a_clear4: assert property (p_clear4) else $error("status bit 4 not cleared");

    // An event is never lost to a clear in the same cycle
    property p_set;
        @(posedge clock) disable iff (rst)
            sts_set != 6'h00 |=> (st_reg.sts & $past(sts_set)) == $past(sts_set);
    endproperty
    a_set: assert property (p_set) else $error("status event dropped");

    property p_kbd_data_gpio;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[8][3:2] != 2'b10 && !st_reg.sts[0]) |=> !st_reg.sts[0];
    endproperty
    a_kbd_data_gpio: assert property (p_kbd_data_gpio) else $error("event outside edge mode");

    property p_kbd_alt;
        @(posedge clock) disable iff (rst) st_reg.cfg[8][3:2] == 2'b11 |-> func_sel[8];
    endproperty
    a_kbd_alt: assert property (p_kbd_alt) else $error("kbd data function not selected");

    property p_keyboard_clock_alt;
        @(posedge clock) disable iff (rst) st_reg.cfg[9][3:2] == 2'b11 |-> func_sel[9];
    endproperty
    a_keyboard_clock_alt: assert property (p_keyboard_clock_alt) else $error("kbd clock function not selected");

    property p_push_pull;
        @(posedge clock) disable iff (rst)
            (!st_reg.cfg[0][`RGPC_BIT_DIR] && !st_reg.cfg[0][`RGPC_BIT_OD]) |-> pin_oe[0];
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull output not driven");

    property p_pol;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[0][3:0] == 4'b0010 && !st_reg.cfg[0][7]) |-> pin_out[0] == !st_reg.dout[0];
    endproperty
    a_pol: assert property (p_pol) else $error("output not inverted");

    property p_od_low;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[0] == 8'h80 && !st_reg.dout[0]) |-> pin_oe[0] && !pin_out[0];
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain did not pull low");

    property p_port17;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[10][3:0] == 4'b1000 && !st_reg.cfg[10][7])
            |-> pin_oe[10] && pin_out[10] == kbc_port_17_output;
    endproperty
    a_port17: assert property (p_port17) else $error("port-17 output not routed");

    property p_mgmt;
        @(posedge clock) disable iff (rst)
            (st_reg.cfg[10][3:0] == 4'b0100 && !st_reg.cfg[10][7])
            |-> func_sel[10] && pin_out[10] == func_out[10];
    endproperty
    a_mgmt: assert property (p_mgmt) else $error("management irq not routed");

    property p_fpr;
        @(posedge clock) disable iff (rst) st_reg.cfg[11][`RGPC_BIT_ALT] |-> func_sel[11];
    endproperty
    a_fpr: assert property (p_fpr) else $error("front-panel reset not selected");

    // Read data stand only after a read strobe, so idle reads cannot alias
    property p_rd_idle;
        @(posedge clock) disable iff (rst) !rd |=> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

endmodule

/* File: tb/rgpc_pins.sv */
// Outside world of the pins: pull-ups plus optional outside drivers
`timescale 1ns/1ns

module rgpc_pins (
    // Device side
    input  wire logic [13:0] pin_out,
    input  wire logic [13:0] pin_oe,
    output logic      [13:0] pin_in,
    // Outside drivers, steered by the bench
    input  wire logic [13:0] ext_en,
    input  wire logic [13:0] ext_val
);
    // Device drive wins; a pin nobody drives floats up to its pull-up
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

/* File: tb/runtime_gpio_pin_config_tb.sv */
// Self-checking bench for the runtime pin configuration block
`timescale 1ns/1ns
`include "rgpc_consts.svh"

module runtime_gpio_pin_config_tb;
    logic        clock;
    logic        rst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic [13:0] pin_in;
    logic [13:0] pin_out;
    logic [13:0] pin_oe;
    logic [13:0] func_out;
    logic        kbc_port_17_output;
    logic [13:0] func_in;
    logic [13:0] func_sel;
    logic [13:0] ext_en;
    logic [13:0] ext_val;
    logic [7:0]  v;
    int          err_count;
    int          compares;
    // Ordinary cases: offset, value written, value read back
    logic [23:0] rows [8] = '{{`RGPC_OFS_B1P0, 8'hFF, 8'h87}, {`RGPC_OFS_B1P7, 8'h7A, 8'h02},
        {`RGPC_OFS_KBD_DATA, 8'hFE, 8'h8E}, {`RGPC_OFS_KBD_CLK, 8'h70, 8'h00},
        {`RGPC_OFS_P27, 8'h5E, 8'h0E}, {`RGPC_OFS_P30, 8'h00, 8'h00},
        {8'h30, 8'hFF, 8'h00}, {`RGPC_OFS_STS, 8'hFF, 8'h00}};
    logic [15:0] rst_rows [5] = '{{`RGPC_OFS_STS, 8'h00}, {`RGPC_OFS_KBD_DATA, 8'h8C},
        {`RGPC_OFS_KBD_CLK, 8'h8C}, {`RGPC_OFS_P27, 8'h01}, {`RGPC_OFS_P30, 8'h05}};
    logic [7:0]  b1_ofs [8] = '{`RGPC_OFS_B1P0, `RGPC_OFS_B1P1, `RGPC_OFS_B1P2,
        `RGPC_OFS_B1P3, `RGPC_OFS_B1P4, `RGPC_OFS_B1P5, `RGPC_OFS_B1P6, `RGPC_OFS_B1P7};
    logic [7:0]  e_ofs [4] = '{`RGPC_OFS_KBD_DATA, `RGPC_OFS_KBD_CLK,
        `RGPC_OFS_P60, `RGPC_OFS_P61};
    logic [7:0]  e_bit [4] = '{8'h01, 8'h02, 8'h10, 8'h20};
    int          e_pin [4] = '{8, 9, 12, 13};

    rgpc_top u_dut (
        .clock              (clock),
        .rst                (rst),
        .addr               (addr),
        .wdata              (wdata),
        .wr                 (wr),
        .rd                 (rd),
        .rdata              (rdata),
        .pin_in             (pin_in),
        .pin_out            (pin_out),
        .pin_oe             (pin_oe),
        .func_out           (func_out),
        .kbc_port_17_output (kbc_port_17_output),
        .func_in            (func_in),
        .func_sel           (func_sel)
    );

    rgpc_pins u_pins (
        .pin_out (pin_out),
        .pin_oe  (pin_oe),
        .pin_in  (pin_in),
        .ext_en  (ext_en),
        .ext_val (ext_val)
    );

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic settle;
        @(posedge clock);
        #1;
    endtask

    task automatic do_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
    endtask

    task automatic check_resets;
        foreach (b1_ofs[i]) begin
            reg_rd(b1_ofs[i]);
            check(v, 8'h01);
        end
        foreach (rst_rows[i]) begin
            reg_rd(rst_rows[i][15:8]);
            check(v, rst_rows[i][7:0]);
        end
    endtask

    task automatic give_verdict;
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        func_out = 14'h0000;
        kbc_port_17_output = 1'b0;
        ext_en = 14'h0000;
        ext_val = 14'h0000;
        err_count = 0;
        compares = 0;
        do_reset();
        check_resets();
        check(pin_oe[7:0], 8'h00);
        // Register table, reserved bits and an unmapped offset
        foreach (rows[i]) begin
            reg_wr(rows[i][23:16], rows[i][15:8]); // keyboard rows keep direction 0
            reg_rd(rows[i][23:16]);
            check(v, rows[i][7:0]);
        end
        // Pin 0 as output: push-pull, inverted, then open drain
        reg_wr(`RGPC_OFS_B1P0, 8'h00);
        reg_wr(`RGPC_OFS_DATA1, 8'h01);
        settle();
        check({6'h00, pin_oe[0], pin_out[0]}, 8'h03);
        reg_wr(`RGPC_OFS_B1P0, 8'h02);
        settle();
        check({6'h00, pin_oe[0], pin_out[0]}, 8'h02);
        reg_wr(`RGPC_OFS_B1P0, 8'h80);
        settle();
        check({6'h00, pin_oe[0], pin_out[0]}, 8'h00);
        reg_wr(`RGPC_OFS_DATA1, 8'h00);
        settle();
        check({6'h00, pin_oe[0], pin_out[0]}, 8'h02);
        // Serial-port-3 signals reach each bank-one pin; latch stays 0
        @(posedge clock);
        func_out <= 14'h00FF;
        foreach (b1_ofs[i]) begin
            reg_wr(b1_ofs[i], 8'h04);
            settle();
            check({6'h00, func_sel[i], pin_out[i]}, 8'h03);
            reg_wr(b1_ofs[i], 8'h01);
        end
        // Inputs: pin 3 pulled low outside, then read inverted
        @(posedge clock);
        ext_en <= 14'h3308;
        repeat (4) settle();
        reg_rd(`RGPC_OFS_DATA1);
        check(v, 8'hF7);
        check(func_in[7:0], 8'hF7);
        reg_wr(`RGPC_OFS_B1P3, 8'h03);
        reg_rd(`RGPC_OFS_DATA1);
        check(v, 8'hFF);
        check(func_in[7:0], 8'hFF);
        // Either-edge inputs: rise and fall each set the same bit, the pin's own
        foreach (e_ofs[i]) reg_wr(e_ofs[i], 8'h09);
        reg_wr(`RGPC_OFS_STS, 8'h3F);
        for (int i = 0; i < 4; i++) begin
            for (int k = 1; k >= 0; k--) begin
                @(posedge clock);
                ext_val[e_pin[i]] <= k[0];
                repeat (5) @(posedge clock);
                reg_rd(`RGPC_OFS_STS);
                check(v, e_bit[i]);
                reg_wr(`RGPC_OFS_STS, ~e_bit[i]);
                reg_rd(`RGPC_OFS_STS);
                check(v, e_bit[i]);
                reg_wr(`RGPC_OFS_STS, e_bit[i]);
                reg_rd(`RGPC_OFS_STS);
                check(v, 8'h00);
            end
        end
        // A plain GPIO pin records no edge
        reg_wr(`RGPC_OFS_KBD_DATA, 8'h01);
        @(posedge clock);
        ext_val <= 14'h0100;
        repeat (5) @(posedge clock);
        reg_rd(`RGPC_OFS_STS);
        check(v, 8'h00);
        // Pin two-seven sources and pin three-zero front-panel reset
        @(posedge clock);
        kbc_port_17_output <= 1'b1;
        func_out <= 14'h0800;
        reg_wr(`RGPC_OFS_P27, 8'h08);
        settle();
        check({5'h00, func_sel[10], pin_oe[10], pin_out[10]}, 8'h03);
        reg_wr(`RGPC_OFS_P27, 8'h04);
        settle();
        check({5'h00, func_sel[10], pin_oe[10], pin_out[10]}, 8'h06);
        reg_wr(`RGPC_OFS_P30, 8'h04);
        settle();
        check({6'h00, func_sel[11], pin_out[11]}, 8'h03);
        reg_wr(`RGPC_OFS_P30, 8'h00);
        settle();
        check({6'h00, func_sel[11], pin_out[11]}, 8'h00);
        // Leave an event pending, then reset in mid-run
        reg_wr(`RGPC_OFS_KBD_DATA, 8'h09);
        @(posedge clock);
        ext_val <= 14'h0000;
        repeat (5) @(posedge clock);
        do_reset();
        check_resets();
        give_verdict();
    end
endmodule
